// *** inc/hmg_pkg.sv ***
package hmg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int HMG_SPW = 16;
  localparam int HMG_PW  = 32;

  // ----------------------------------------------------------------
  // Method code low digit
  // ----------------------------------------------------------------
  localparam logic [3:0] HMG_M_REAR   = 4'h5;
  localparam logic [3:0] HMG_M_COUNT  = 4'h6;
  localparam logic [3:0] HMG_M_CRADLE = 4'h7;

  // ----------------------------------------------------------------
  // Controller register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] HMG_R_CTRL   = 6'h00;
  localparam logic [5:0] HMG_R_METHOD = 6'h04;
  localparam logic [5:0] HMG_R_FAST   = 6'h08;
  localparam logic [5:0] HMG_R_CREEP  = 6'h0C;
  localparam logic [5:0] HMG_R_SHIFT  = 6'h10;
  localparam logic [5:0] HMG_R_POST   = 6'h14;
  localparam logic [5:0] HMG_R_HOME   = 6'h18;
  localparam logic [5:0] HMG_R_ACCEL  = 6'h1C;
  localparam logic [5:0] HMG_R_STAT   = 6'h20;
  localparam logic [5:0] HMG_R_POS    = 6'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HMG_C_AUTO  = 0;
  localparam int HMG_C_RRSEL = 1;
  localparam int HMG_C_START = 2;
  localparam int HMG_C_TWO   = 3;
  localparam int HMG_C_PLO   = 4;
  localparam int HMG_C_PHI   = 9;
  localparam int HMG_M_DIR   = 16;
  localparam int HMG_M_POL   = 17;
  localparam int HMG_S_BUSY  = 0;
  localparam int HMG_S_DONE  = 1;
  localparam int HMG_S_ERR   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] HMG_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] HMG_METHOD_RST = 32'h0000_0005;
  localparam logic [31:0] HMG_SPD_RST    = 32'h0000_0010;
  localparam logic [31:0] HMG_CREEP_RST  = 32'h0000_0004;
  localparam logic [31:0] HMG_DIST_RST   = 32'h0000_0000;
  localparam logic [31:0] HMG_ACCEL_RST  = 32'h0000_0002;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {HMG_IDLE, HMG_FAST, HMG_DOG, HMG_COUNT} hmg_state_e;

endpackage : hmg_pkg

// *** inc/hmg_if.sv ***
`timescale 1ns/1ps
interface hmg_if;
  import hmg_pkg::*;
  logic                 auto_manual_select;
  logic [4:0]           point_entry_select_low;
  logic [2:0]           point_entry_select_high;
  logic                 remote_register_position_select;
  logic                 two_station;
  logic                 homing_req;
  logic [15:0]          homing_method_code;
  logic                 homing_direction;
  logic                 proximity_input_polarity;
  logic [HMG_SPW-1:0]   homing_fast_speed;
  logic [HMG_SPW-1:0]   creep_speed_setting;
  logic [HMG_SPW-1:0]   accel_time;
  logic [HMG_PW-1:0]    home_shift_distance;
  logic [HMG_PW-1:0]    post_proximity_travel;
  logic [HMG_PW-1:0]    home_position_value;
  logic                 homing_busy;
  logic                 homing_done;
  logic                 homing_error;
  logic [HMG_PW-1:0]    current_position;

  modport drive (
    input  auto_manual_select, point_entry_select_low, point_entry_select_high,
           remote_register_position_select, two_station, homing_req,
           homing_method_code, homing_direction, proximity_input_polarity,
           homing_fast_speed, creep_speed_setting, accel_time, home_shift_distance,
           post_proximity_travel, home_position_value,
    output homing_busy, homing_done, homing_error, current_position
  );

  modport master (
    output auto_manual_select, point_entry_select_low, point_entry_select_high,
           remote_register_position_select, two_station, homing_req,
           homing_method_code, homing_direction, proximity_input_polarity,
           homing_fast_speed, creep_speed_setting, accel_time, home_shift_distance,
           post_proximity_travel, home_position_value,
    input  homing_busy, homing_done, homing_error, current_position
  );
endinterface : hmg_if

// *** verilog/hmg_sync.sv ***
`timescale 1ns/1ps
module hmg_sync
  import hmg_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic pin,
  input  wire logic polarity,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
  } hmg_sync_s;

  hmg_sync_s s_q;
  hmg_sync_s s_d;

  // ----------------------------------------------------------------
  // Two-stage capture, then polarity, then edge detect
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d     = s_q;
    s_d.s1  = pin;
    s_d.s2  = s_q.s1;
    s_d.lvl = s_q.s2 ^ polarity;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Edges compare the next level with the registered one so each is seen exactly once
  assign level = s_q.lvl;
  assign rise  = s_d.lvl & ~s_q.lvl;
  assign fall  = ~s_d.lvl & s_q.lvl;

endmodule : hmg_sync

// *** verilog/hmg_drive.sv ***
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module hmg_drive
  import hmg_pkg::*;
#(
  parameter int SPW = HMG_SPW,
  parameter int PW  = HMG_PW
)
(
  input  wire logic     sys_clk,
  input  wire logic     nrst,
  hmg_if.drive          lnk,
  input  wire logic     proximity_pin,
  input  wire logic     enc_step,
  input  wire logic     enc_index,
  output logic [SPW-1:0] speed_cmd,
  output logic          dir_cmd
);

  typedef struct packed {
    hmg_state_e      st;
    logic [3:0]      meth;
    logic            dir;
    logic [SPW-1:0]  spd;
    logic [SPW-1:0]  acnt;
    logic [PW-1:0]   pos;
    logic [PW:0]     trav;
    logic            done;
    logic            err;
  } hmg_drv_s;

  hmg_drv_s       s_q;
  hmg_drv_s       s_d;
  logic           dog_rise;
  logic           dog_fall;
  logic           start_ok;
  logic           meth_ok;
  logic [SPW-1:0] target;
  logic [PW:0]    goal;
  logic           finish;

  hmg_sync u_dog (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pin      (proximity_pin),
    .polarity (lnk.proximity_input_polarity),
    .level    (),
    .rise     (dog_rise),
    .fall     (dog_fall)
  );

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  // A request outside manual mode, with a point entry selected, or
  // without the register select on a two-station drive is refused.
  assign start_ok = lnk.auto_manual_select
                  & (lnk.point_entry_select_low == 5'h00)
                  & (lnk.point_entry_select_high == 3'h0)
                  & (~lnk.two_station | lnk.remote_register_position_select);

  assign meth_ok = (lnk.homing_method_code[3:0] == HMG_M_REAR)
                 | (lnk.homing_method_code[3:0] == HMG_M_COUNT)
                 | (lnk.homing_method_code[3:0] == HMG_M_CRADLE);

  // Post travel plus shift; one extra bit keeps the sum from wrapping
  assign goal = {1'b0, lnk.post_proximity_travel} + {1'b0, lnk.home_shift_distance};

  // ----------------------------------------------------------------
  // Speed target per phase
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (s_q.st)
      HMG_IDLE:  target = '0;
      HMG_FAST:  target = lnk.homing_fast_speed;
      HMG_DOG:   target = lnk.creep_speed_setting;
      HMG_COUNT: target = lnk.creep_speed_setting;
    endcase
  end

  // Home is fixed by distance for rear/count, by index for cradle
  always_comb
  begin
    finish = 1'b0;
    if (s_q.st == HMG_COUNT)
      finish = enc_step && ((s_q.trav + 1'b1) >= goal);
    else if (s_q.st == HMG_DOG && s_q.meth == HMG_M_CRADLE)
      finish = enc_index;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Ramp one unit per accel_time cycles toward the target
    if (s_q.spd == target)
      s_d.acnt = '0;
    else if (s_q.acnt + 1'b1 >= lnk.accel_time)
    begin
      s_d.acnt = '0;
      if (s_q.spd < target)
        s_d.spd = s_q.spd + 1'b1;
      else
        s_d.spd = s_q.spd - 1'b1;
    end
    else
      s_d.acnt = s_q.acnt + 1'b1;

    if (enc_step)
    begin
      if (s_q.dir)
        s_d.pos = s_q.pos - 1'b1;
      else
        s_d.pos = s_q.pos + 1'b1;
    end

    unique case (s_q.st)
      HMG_IDLE:
      begin
        if (lnk.homing_req)
        begin
          if (start_ok && meth_ok)
          begin
            s_d.st   = HMG_FAST;
            s_d.meth = lnk.homing_method_code[3:0];
            s_d.dir  = lnk.homing_direction;
            s_d.done = 1'b0;
            s_d.err  = 1'b0;
          end
          else
          begin
            s_d.err  = 1'b1;
            s_d.done = 1'b0;
          end
        end
      end
      HMG_FAST:
      begin
        // Front edge is taken at sample time, hence speed-dependent error
        if (dog_rise)
        begin
          s_d.trav = '0;
          if (s_q.meth == HMG_M_COUNT)
            s_d.st = HMG_COUNT;
          else
            s_d.st = HMG_DOG;
        end
      end
      HMG_DOG:
      begin
        if (s_q.meth == HMG_M_REAR && dog_fall)
        begin
          s_d.trav = '0;
          s_d.st   = HMG_COUNT;
        end
      end
      HMG_COUNT:
      begin
        if (enc_step)
          s_d.trav = s_q.trav + 1'b1;
      end
    endcase

    if (finish)
    begin
      s_d.st   = HMG_IDLE;
      s_d.pos  = lnk.home_position_value;
      s_d.spd  = '0;
      s_d.acnt = '0;
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_q      <= '0;
      s_q.st   <= HMG_IDLE;
      s_q.meth <= HMG_METHOD_RST[3:0];
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign speed_cmd            = s_q.spd;
  assign dir_cmd              = s_q.dir;
  assign lnk.homing_busy      = (s_q.st != HMG_IDLE);
  assign lnk.homing_done      = s_q.done;
  assign lnk.homing_error     = s_q.err;
  assign lnk.current_position = s_q.pos;

endmodule : hmg_drive

// *** verilog/hmg_master.sv ***
`timescale 1ns/1ps
module hmg_master
  import hmg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  hmg_if.master            lnk,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] meth;
    logic [31:0] fast;
    logic [31:0] creep;
    logic [31:0] shift;
    logic [31:0] post;
    logic [31:0] home;
    logic [31:0] accel;
    logic [31:0] rdata;
    logic        ack;
    logic        req;
  } hmg_mst_s;

  hmg_mst_s s_q;
  hmg_mst_s s_d;
  logic     acc;
  logic     wr_go;

  // One wait cycle per access keeps read data registered; a write
  // lands only on the edge that completes it, never while stalled
  assign acc             = (avs_read | avs_write) & ~s_q.ack;
  assign wr_go           = avs_write & s_q.ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d     = s_q;
    s_d.ack = acc;
    s_d.req = 1'b0;
    if (wr_go)
    begin
      unique case (avs_address)
        HMG_R_CTRL:
        begin
          s_d.ctrl = avs_writedata;
          s_d.ctrl[HMG_C_START] = 1'b0;
          s_d.req = avs_writedata[HMG_C_START];
        end
        HMG_R_METHOD: s_d.meth  = avs_writedata;
        HMG_R_FAST:   s_d.fast  = avs_writedata;
        HMG_R_CREEP:  s_d.creep = avs_writedata;
        HMG_R_SHIFT:  s_d.shift = avs_writedata;
        HMG_R_POST:   s_d.post  = avs_writedata;
        HMG_R_HOME:   s_d.home  = avs_writedata;
        HMG_R_ACCEL:  s_d.accel = avs_writedata;
        default:      s_d.rdata = s_q.rdata;
      endcase
    end
    if (acc && avs_read)
    begin
      unique case (avs_address)
        HMG_R_CTRL:   s_d.rdata = s_q.ctrl;
        HMG_R_METHOD: s_d.rdata = s_q.meth;
        HMG_R_FAST:   s_d.rdata = s_q.fast;
        HMG_R_CREEP:  s_d.rdata = s_q.creep;
        HMG_R_SHIFT:  s_d.rdata = s_q.shift;
        HMG_R_POST:   s_d.rdata = s_q.post;
        HMG_R_HOME:   s_d.rdata = s_q.home;
        HMG_R_ACCEL:  s_d.rdata = s_q.accel;
        HMG_R_STAT:   s_d.rdata = {29'h0, lnk.homing_error,
                                   lnk.homing_done, lnk.homing_busy};
        HMG_R_POS:    s_d.rdata = lnk.current_position;
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_q       <= '0;
      s_q.ctrl  <= HMG_CTRL_RST;
      s_q.meth  <= HMG_METHOD_RST;
      s_q.fast  <= HMG_SPD_RST;
      s_q.creep <= HMG_CREEP_RST;
      s_q.shift <= HMG_DIST_RST;
      s_q.post  <= HMG_DIST_RST;
      s_q.home  <= HMG_DIST_RST;
      s_q.accel <= HMG_ACCEL_RST;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Remote bits toward the drive
  // ----------------------------------------------------------------
  // Mode and point selects are taken from the same write that carries start;
  // the pulse is only issued by the start write itself.
  assign avs_readdata                        = s_q.rdata;
  assign lnk.auto_manual_select              = s_q.ctrl[HMG_C_AUTO];
  assign lnk.point_entry_select_low          = s_q.ctrl[HMG_C_PLO +: 5];
  assign lnk.point_entry_select_high         = s_q.ctrl[HMG_C_PHI +: 3];
  assign lnk.remote_register_position_select = s_q.ctrl[HMG_C_RRSEL];
  assign lnk.two_station                     = s_q.ctrl[HMG_C_TWO];
  assign lnk.homing_req                      = s_q.req;
  assign lnk.homing_method_code              = s_q.meth[15:0];
  assign lnk.homing_direction                = s_q.meth[HMG_M_DIR];
  assign lnk.proximity_input_polarity        = s_q.meth[HMG_M_POL];
  assign lnk.homing_fast_speed               = s_q.fast[HMG_SPW-1:0];
  assign lnk.creep_speed_setting             = s_q.creep[HMG_SPW-1:0];
  assign lnk.accel_time                      = s_q.accel[HMG_SPW-1:0];
  assign lnk.home_shift_distance             = s_q.shift[HMG_PW-1:0];
  assign lnk.post_proximity_travel           = s_q.post[HMG_PW-1:0];
  assign lnk.home_position_value             = s_q.home[HMG_PW-1:0];

endmodule : hmg_master

// *** dv/hmg_sva.sv ***
`timescale 1ns/1ps
module hmg_sva
  import hmg_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              homing_req,
  input wire logic              homing_busy,
  input wire logic              homing_done,
  input wire logic              homing_error,
  input wire logic              auto_manual_select,
  input wire logic [4:0]        point_entry_select_low,
  input wire logic [2:0]        point_entry_select_high,
  input wire logic              remote_register_position_select,
  input wire logic              two_station,
  input wire logic [15:0]       homing_method_code,
  input wire logic [HMG_PW-1:0] home_position_value,
  input wire logic [HMG_PW-1:0] current_position
);
  logic mode_ok;
  logic code_ok;
  logic pts_on;

  assign pts_on  = (point_entry_select_low != 5'h00) || (point_entry_select_high != 3'h0);
  assign mode_ok = auto_manual_select && !pts_on
                   && (!two_station || remote_register_position_select);
  assign code_ok = homing_method_code[3:0] inside {HMG_M_REAR, HMG_M_COUNT, HMG_M_CRADLE};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Start handshake
  // ----------------------------------------------------------------
  sequence s_take;
    homing_req && !homing_busy;
  endsequence
  sequence s_run;
    homing_busy && !homing_done && !homing_error;
  endsequence
  sequence s_refuse;
    homing_error && !homing_done && !homing_busy;
  endsequence

  a_start_taken: assert property (s_take ##0 (mode_ok && code_ok) |=> s_run)
    else $error("legal start not taken");
  a_manual_needed: assert property (s_take ##0 !auto_manual_select |=> s_refuse)
    else $error("start without manual mode not refused");
  a_points_off: assert property (s_take ##0 pts_on |=> s_refuse)
    else $error("start with point select not refused");
  a_two_station: assert property (
    s_take ##0 (two_station && !remote_register_position_select) |=> s_refuse)
    else $error("two station start without register select not refused");
  a_bad_code: assert property (s_take ##0 !code_ok |=> s_refuse)
    else $error("unknown method started");

  // ----------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------
  a_home_loaded: assert property ($rose(homing_done)
    |-> current_position == home_position_value)
    else $error("home value not loaded at completion");
  a_done_holds: assert property (homing_done && !homing_req |=> homing_done)
    else $error("done dropped without new request");
  a_busy_ends: assert property ($past(nrst) && $fell(homing_busy)
    |-> homing_done && !homing_error)
    else $error("busy ended without done");
  a_req_pulse: assert property (homing_req |=> !homing_req)
    else $error("start request longer than one cycle");
endmodule : hmg_sva

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import hmg_pkg::*;
  logic               sys_clk;
  logic               nrst;
  logic               proximity_pin;
  logic               enc_step;
  logic               enc_index;
  logic [5:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [HMG_SPW-1:0] speed_cmd;
  logic               dir_cmd;
  logic [31:0]        rdv;
  int                 err_total;
  int                 checks;
  logic [31:0]        bad_ctrl [5] = '{32'h4, 32'h15, 32'h205, 32'hD, 32'h5};
  logic [31:0]        bad_meth [5] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h2};

  hmg_if lnk ();
  hmg_master hmg_master_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  hmg_drive hmg_drive_i (.sys_clk(sys_clk), .nrst(nrst), .lnk(lnk),
    .proximity_pin(proximity_pin), .enc_step(enc_step), .enc_index(enc_index),
    .speed_cmd(speed_cmd), .dir_cmd(dir_cmd));
  hmg_sva hmg_sva_i (.sys_clk(sys_clk), .nrst(nrst), .homing_req(lnk.homing_req),
    .homing_busy(lnk.homing_busy), .homing_done(lnk.homing_done),
    .homing_error(lnk.homing_error), .auto_manual_select(lnk.auto_manual_select),
    .point_entry_select_low(lnk.point_entry_select_low),
    .point_entry_select_high(lnk.point_entry_select_high),
    .remote_register_position_select(lnk.remote_register_position_select),
    .two_station(lnk.two_station), .homing_method_code(lnk.homing_method_code),
    .home_position_value(lnk.home_position_value),
    .current_position(lnk.current_position));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // Waitrequest and read data are taken at the rising edge itself,
  // before the slave's registers move on that edge
  task automatic bus(input logic wr_en, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 20)
    begin
      err_total++;
      close_out();
    end
    rdv = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc

  task automatic pulse(input int k, input logic idx);
    repeat (k)
    begin
      @(posedge sys_clk);
      enc_step  <= ~idx;
      enc_index <= idx;
      @(posedge sys_clk);
      enc_step  <= 1'b0;
      enc_index <= 1'b0;
    end
  endtask : pulse

  task automatic pin(input logic v);
    @(posedge sys_clk);
    proximity_pin <= v;
  endtask : pin

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_total = 0;
    checks = 0;
    nrst = 1'b0;
    proximity_pin = 1'b0;
    enc_step = 1'b0;
    enc_index = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    rd("ctrl", HMG_R_CTRL, HMG_CTRL_RST);
    rd("method", HMG_R_METHOD, HMG_METHOD_RST);
    rd("fast", HMG_R_FAST, HMG_SPD_RST);
    rd("creep", HMG_R_CREEP, HMG_CREEP_RST);
    rd("accel", HMG_R_ACCEL, HMG_ACCEL_RST);
    rd("pos", HMG_R_POS, 32'h0);
    wr(HMG_R_STAT, 32'hFFFF_FFFF);
    rd("stat", HMG_R_STAT, 32'h0);
    rd("unmapped", 6'h28, 32'h0);
    $display("test registers done");
    // Each entry breaks exactly one start condition
    for (int i = 0; i < 5; i++)
    begin
      wr(HMG_R_METHOD, bad_meth[i]);
      wr(HMG_R_CTRL, bad_ctrl[i]);
      cyc(2);
      rd("refused", HMG_R_STAT, 32'h4);
      chk("idle speed", 32'h0, {16'h0, speed_cmd});
    end
    $display("test refusals done");
    wr(HMG_R_POST, 32'h3);
    wr(HMG_R_SHIFT, 32'h2);
    wr(HMG_R_HOME, 32'h0000_1234);
    wr(HMG_R_METHOD, 32'h0001_0006);
    wr(HMG_R_CTRL, 32'h0000_000B);
    wr(HMG_R_CTRL, 32'h0000_000F);
    cyc(10);
    chk("ramping", 32'h1, {31'h0, speed_cmd < HMG_SPW'(HMG_SPD_RST)});
    chk("dir up", 32'h1, {31'h0, dir_cmd});
    cyc(40);
    chk("fast", HMG_SPD_RST, {16'h0, speed_cmd});
    pulse(1, 1'b1);
    pin(1'b1);
    cyc(40);
    chk("creep", HMG_CREEP_RST, {16'h0, speed_cmd});
    pulse(4, 1'b0);
    cyc(2);
    rd("count busy", HMG_R_STAT, 32'h1);
    pulse(1, 1'b0);
    cyc(2);
    rd("count done", HMG_R_STAT, 32'h2);
    rd("count home", HMG_R_POS, 32'h0000_1234);
    chk("stopped", 32'h0, {16'h0, speed_cmd});
    $display("test count method done");
    // Inverted sensor: a low pin means the dog is present
    wr(HMG_R_METHOD, 32'h0002_0005);
    pin(1'b1);
    wr(HMG_R_POST, 32'h1);
    wr(HMG_R_SHIFT, 32'h1);
    wr(HMG_R_HOME, 32'h0000_00A5);
    wr(HMG_R_CTRL, 32'h5);
    cyc(4);
    chk("dir down", 32'h0, {31'h0, dir_cmd});
    pin(1'b0);
    cyc(6);
    pulse(3, 1'b0);
    pulse(1, 1'b1);
    cyc(2);
    rd("in dog busy", HMG_R_STAT, 32'h1);
    pin(1'b1);
    cyc(6);
    pulse(1, 1'b0);
    cyc(2);
    rd("shift busy", HMG_R_STAT, 32'h1);
    pulse(1, 1'b0);
    cyc(2);
    rd("rear done", HMG_R_STAT, 32'h2);
    rd("rear home", HMG_R_POS, 32'h0000_00A5);
    $display("test rear method done");
    wr(HMG_R_METHOD, 32'h7);
    pin(1'b0);
    wr(HMG_R_HOME, 32'h0000_0077);
    wr(HMG_R_CTRL, 32'h5);
    pulse(1, 1'b1);
    cyc(2);
    rd("index early", HMG_R_STAT, 32'h1);
    wr(HMG_R_CTRL, 32'h5);
    rd("restart ignored", HMG_R_STAT, 32'h1);
    pin(1'b1);
    cyc(6);
    pulse(1, 1'b1);
    cyc(2);
    rd("cradle done", HMG_R_STAT, 32'h2);
    rd("cradle home", HMG_R_POS, 32'h0000_0077);
    $display("test cradle method done");
    close_out();
  end
endmodule : testbench
